// [dsc_pkg.sv]
// Package for the disk controller switch configuration block.
// Holds timing counts, register offsets, field layouts and carrier structs.
// Assumes a 20 MHz core clock and an 18-bit host-bus I/O address.
package dsc_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned DSC_CLK_HZ = 20_000_000;
   localparam int unsigned DSC_BOOT_TIMEOUT_S = 1 * 60;
   localparam int unsigned DSC_BOOT_TIMEOUT_CYC = DSC_BOOT_TIMEOUT_S * DSC_CLK_HZ;
   localparam int unsigned DSC_BURST_SHORT_US = 4;
   localparam int unsigned DSC_BURST_LONG_US = 8;
   localparam int unsigned DSC_BURST_SHORT_CYC = DSC_BURST_SHORT_US * (DSC_CLK_HZ / 1_000_000);
   localparam int unsigned DSC_BURST_LONG_CYC = DSC_BURST_LONG_US * (DSC_CLK_HZ / 1_000_000);

   // ************************************************************
   // Addressing
   // ************************************************************
   localparam int DSC_BUS_AW = 18;
   localparam int DSC_DMA_AW = 22;
   localparam int DSC_NARROW_AW = 18;
   localparam logic [17:0] DSC_STD_BASE = 18'o772150;
   localparam logic [17:0] DSC_ALT1_BASE = 18'o772154;
   localparam logic [17:0] DSC_ALT2_BASE = 18'o760334;
   localparam logic [17:0] DSC_BASE_STEP = 18'o000004;
   localparam logic [17:0] DSC_OFF_POLL = 18'o000000;
   localparam logic [17:0] DSC_OFF_STATUS = 18'o000002;

   // ************************************************************
   // Status word layout and reset values
   // ************************************************************
   localparam int DSC_ST_ERR_BIT = 15;
   localparam int DSC_ST_HALT_BIT = 14;
   localparam int DSC_ST_BOOTOK_BIT = 13;
   localparam logic [15:0] DSC_ST_RESET = 16'h0000;
   localparam logic [11:0] DSC_ERR_CODE_DEF = 12'h0a5;
   localparam logic [7:0] DSC_VEC_RESET = 8'h00;
   localparam logic [2:0] DSC_UNIT8_CODE = 3'h0;
   localparam logic [3:0] DSC_UNIT8 = 4'h8;
   localparam int DSC_UNITS = 8;

   typedef enum logic [1:0] {
      DSC_BOOT_IDLE = 2'b00,
      DSC_BOOT_WAIT = 2'b01,
      DSC_BOOT_DONE = 2'b10,
      DSC_BOOT_FAIL = 2'b11
   } dsc_boot_e;

   typedef struct packed {
      logic autoboot;
      logic [2:0] addr_sel;
      logic [2:0] unit_sel;
      logic wide;
      logic burst_long;
      logic pulse_from_a;
   } dsc_sw_s;

   typedef struct packed {
      logic [17:0] base;
      logic standard;
      logic autoboot;
      logic [2:0] boot_unit;
      logic [3:0] first_unit;
      logic wide;
      logic burst_long;
      logic pulse_from_a;
   } dsc_cfg_s;

endpackage

// [dsc_strap_latch.sv]
// Switch capture and decode for the disk controller configuration block.
// Assumes switch levels are synchronous to CLK and steady while the
// run/halt switch is released.
`timescale 1ns/1ps
`default_nettype none
module dsc_strap_latch (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run_halt,
   input wire dsc_pkg::dsc_sw_s sw,
   output dsc_pkg::dsc_cfg_s cfg,
   output logic cfg_valid,
   output logic capture
);
   import dsc_pkg::*;

   // ************************************************************
   // Decode
   // ************************************************************
   logic pending_reg;
   logic pending_next;
   logic valid_reg;
   dsc_cfg_s cfg_reg;
   dsc_cfg_s cfg_next;
   wire [17:0] alt_base = DSC_ALT2_BASE + 18'(DSC_BASE_STEP * 18'(sw.addr_sel - 3'h2));
   wire [17:0] base_dec = (sw.addr_sel == 3'h0) ? DSC_STD_BASE :
                          (sw.addr_sel == 3'h1) ? DSC_ALT1_BASE : alt_base;
   wire [3:0] first_dec = (sw.unit_sel == DSC_UNIT8_CODE) ? DSC_UNIT8 : {1'b0, sw.unit_sel};

   // Strap capture waits until the run/halt switch is released, so a
   // switch changed during halt is taken on the release edge.
   assign capture = pending_reg && !run_halt;
   assign pending_next = run_halt ? 1'b1 : (capture ? 1'b0 : pending_reg);

   always_comb begin
      cfg_next.base = base_dec;
      cfg_next.standard = (sw.addr_sel == 3'h0);
      cfg_next.autoboot = sw.autoboot && (sw.addr_sel == 3'h0);
      cfg_next.boot_unit = sw.unit_sel;
      cfg_next.first_unit = first_dec;
      cfg_next.wide = sw.wide;
      cfg_next.burst_long = sw.burst_long;
      cfg_next.pulse_from_a = sw.pulse_from_a;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pending_reg <= 1'b1;
         valid_reg <= 1'b0;
         cfg_reg <= '0;
      end else if (ce) begin
         pending_reg <= pending_next;
         valid_reg <= run_halt ? 1'b0 : (capture ? 1'b1 : valid_reg);
         if (capture) begin
            cfg_reg <= cfg_next;
         end
      end
   end

   assign cfg = cfg_reg;
   assign cfg_valid = valid_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_CFG_HOLD: assert property (@(posedge clk) disable iff (rst)
      (valid_reg && !capture && !run_halt) |=> $stable(cfg_reg))
      else $error("Configuration changed without a capture.");
   AST_ALT_NOBOOT: assert property (@(posedge clk) disable iff (rst)
      (valid_reg && !cfg_reg.standard) |-> !cfg_reg.autoboot)
      else $error("Autoboot enabled at an alternate base.");
   AST_UNIT8: assert property (@(posedge clk) disable iff (rst)
      (capture && ce && sw.unit_sel == 3'h0) |=> (cfg_reg.first_unit == 4'h8))
      else $error("All-off unit code did not give unit 8.");
endmodule
`default_nettype wire

// [dsc_strap_config.sv]
// Disk controller run-time configuration from option switches.
// Assumes a single-cycle host register port and level switch inputs.
//
// Contract
// - Register base address comes from three address-select switches, eight choices.
// - Code 0 is 772150, 1 is 772154, 2..7 run 760334 to 760360.
// - Registers answer at consecutive word addresses upward from the base.
// - Host writes the interrupt vector; the device uses that written vector.
// - Autoboot at power-up when enabled and at the standard base; the code also starts it after every run/halt release.
// - Boot drive not ready halts the host after one minute.
// - After boot failure an error code shows in the status word at base plus two.
// - At standard base the unit switches give boot unit; only 0 to 3 valid.
// - At an alternate base the unit switches give the first unit, 1 to 8.
// - Unit code is binary, all-off means 8; on,on,off gives 3.
// - Gap between DMA bursts is 4 us with switch off, 8 us on.
// - Index and sector pulses come from the data cable off, control cable on.
// - Full 22-bit DMA address only with switch on and driver fitted.
// - Device takes part in four-level distributed interrupt arbitration.
// - Switches are sampled only at reset or run/halt release.
`timescale 1ns/1ps
`default_nettype none
module dsc_strap_config #(
   parameter int unsigned BOOT_TIMEOUT_CYC = dsc_pkg::DSC_BOOT_TIMEOUT_CYC,
   parameter logic [11:0] ERR_CODE = dsc_pkg::DSC_ERR_CODE_DEF,
   parameter int IRQ_LEVEL = 4
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic RUN_HALT,
   input wire dsc_pkg::dsc_sw_s SW,
   input wire logic WIDE_DRIVER_FITTED,
   input wire logic [dsc_pkg::DSC_BUS_AW-1:0] BUS_ADDR,
   input wire logic BUS_RD,
   input wire logic BUS_WR,
   input wire logic [15:0] BUS_WDATA,
   output logic [15:0] BUS_RDATA,
   output logic BUS_ACK,
   input wire logic [dsc_pkg::DSC_UNITS-1:0] DRIVE_READY,
   output logic BOOT_REQ,
   output logic [2:0] BOOT_UNIT,
   output logic HOST_HALT,
   output logic [3:0] FIRST_UNIT,
   input wire logic DMA_BURST_END,
   output logic DMA_BURST_ALLOW,
   input wire logic [dsc_pkg::DSC_DMA_AW-1:0] DMA_ADDR_IN,
   output logic [dsc_pkg::DSC_DMA_AW-1:0] DMA_ADDR_OUT,
   input wire logic INDEX_A,
   input wire logic SECTOR_A,
   input wire logic INDEX_B,
   input wire logic SECTOR_B,
   output logic INDEX_PULSE,
   output logic SECTOR_PULSE,
   input wire logic DEV_IRQ,
   input wire logic HIGHER_REQ,
   input wire logic IAK_IN,
   output logic IAK_OUT,
   output logic [3:0] IRQ_LINES,
   output logic [7:0] VEC_OUT,
   output logic VEC_STROBE
);
   import dsc_pkg::*;

   // ************************************************************
   // Switch capture
   // ************************************************************
   dsc_cfg_s cfg;
   logic cfg_valid;
   logic capture;

   dsc_strap_latch u_latch (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .run_halt(RUN_HALT),
      .sw(SW),
      .cfg(cfg),
      .cfg_valid(cfg_valid),
      .capture(capture)
   );

   // ************************************************************
   // Register port
   // ************************************************************
   logic [7:0] vec_reg;
   logic [15:0] rdata_reg;
   logic ack_reg;
   dsc_boot_e boot_reg;
   dsc_boot_e boot_next;
   wire [17:0] off = BUS_ADDR - cfg.base;
   wire sel_poll = cfg_valid && (off == DSC_OFF_POLL);
   wire sel_stat = cfg_valid && (off == DSC_OFF_STATUS);
   wire boot_fail = (boot_reg == DSC_BOOT_FAIL);
   // The error code stays readable while the host sits halted.
   wire [15:0] stat_word = boot_fail ? {1'b1, 1'b1, 2'b00, ERR_CODE} :
                           {2'b00, (boot_reg == DSC_BOOT_DONE), 13'h0000};
   wire [15:0] rd_mux = sel_stat ? stat_word : 16'h0000;
   wire take_rd = BUS_RD && (sel_poll || sel_stat);
   wire take_wr = BUS_WR && (sel_poll || sel_stat);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         vec_reg <= DSC_VEC_RESET;
         rdata_reg <= DSC_ST_RESET;
         ack_reg <= 1'b0;
      end else if (CE) begin
         ack_reg <= take_rd || take_wr;
         if (take_rd) begin
            rdata_reg <= rd_mux;
         end
         if (BUS_WR && sel_stat) begin
            vec_reg <= BUS_WDATA[7:0];
         end
      end
   end

   assign BUS_RDATA = rdata_reg;
   assign BUS_ACK = ack_reg;

   // ************************************************************
   // Autoboot
   // ************************************************************
   logic [31:0] tmo_reg;
   wire unit_ready = DRIVE_READY[cfg.boot_unit] && !cfg.boot_unit[2];
   wire tmo_hit = (tmo_reg == 32'(BOOT_TIMEOUT_CYC - 1));

   always_comb begin
      boot_next = boot_reg;
      case (boot_reg)
         DSC_BOOT_IDLE: begin
            if (capture && cfg_valid == 1'b0 && SW.autoboot && SW.addr_sel == 3'h0) begin
               boot_next = DSC_BOOT_WAIT;
            end
         end
         DSC_BOOT_WAIT: begin
            if (unit_ready) begin
               boot_next = DSC_BOOT_DONE;
            end else if (tmo_hit) begin
               boot_next = DSC_BOOT_FAIL;
            end
         end
         default: begin
            boot_next = boot_reg;
         end
      endcase
      if (RUN_HALT) begin
         boot_next = DSC_BOOT_IDLE;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         boot_reg <= DSC_BOOT_IDLE;
         tmo_reg <= 32'h0000_0000;
      end else if (CE) begin
         boot_reg <= boot_next;
         tmo_reg <= (boot_reg == DSC_BOOT_WAIT) ? tmo_reg + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   assign BOOT_REQ = (boot_reg == DSC_BOOT_WAIT);
   assign BOOT_UNIT = cfg.boot_unit;
   assign HOST_HALT = boot_fail;
   assign FIRST_UNIT = cfg.first_unit;

   // ************************************************************
   // DMA burst spacing and addressing
   // ************************************************************
   logic [7:0] gap_reg;
   wire [7:0] gap_load = cfg.burst_long ? 8'(DSC_BURST_LONG_CYC) : 8'(DSC_BURST_SHORT_CYC);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         gap_reg <= 8'h00;
      end else if (CE) begin
         if (DMA_BURST_END) begin
            gap_reg <= gap_load;
         end else if (gap_reg != 8'h00) begin
            gap_reg <= gap_reg - 8'h01;
         end
      end
   end

   assign DMA_BURST_ALLOW = (gap_reg == 8'h00);
   // Without the driver fitted the upper lines must stay quiet, whatever the switch.
   wire wide_ok = cfg.wide && WIDE_DRIVER_FITTED;
   assign DMA_ADDR_OUT = wide_ok ? DMA_ADDR_IN : {4'h0, DMA_ADDR_IN[DSC_NARROW_AW-1:0]};

   assign INDEX_PULSE = cfg.pulse_from_a ? INDEX_A : INDEX_B;
   assign SECTOR_PULSE = cfg.pulse_from_a ? SECTOR_A : SECTOR_B;

   // ************************************************************
   // Interrupt arbitration
   // ************************************************************
   logic pend_reg;
   logic [7:0] vout_reg;
   logic vstb_reg;
   wire grant = IAK_IN && pend_reg && !HIGHER_REQ;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pend_reg <= 1'b0;
         vout_reg <= 8'h00;
         vstb_reg <= 1'b0;
      end else if (CE) begin
         pend_reg <= DEV_IRQ || (pend_reg && !grant);
         vstb_reg <= grant;
         if (grant) begin
            vout_reg <= vec_reg;
         end
      end
   end

   // The grant passes down the chain unless this device has a request pending.
   assign IAK_OUT = IAK_IN && !pend_reg;
   assign IRQ_LINES = pend_reg ? 4'(4'h1 << (IRQ_LEVEL - 4)) : 4'h0;
   assign VEC_OUT = vout_reg;
   assign VEC_STROBE = vstb_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_STAT_ERR: assert property (@(posedge CLK) disable iff (RST)
      (CE && BUS_RD && sel_stat && boot_fail) |=> (BUS_ACK && BUS_RDATA[11:0] == ERR_CODE))
      else $error("Status word lacks the boot error code.");
   AST_HALT_TMO: assert property (@(posedge CLK) disable iff (RST)
      (CE && !RUN_HALT && BOOT_REQ && tmo_hit && !unit_ready) |=> HOST_HALT)
      else $error("Host not halted at boot timeout.");
   AST_NO_EARLY_HALT: assert property (@(posedge CLK) disable iff (RST)
      $rose(HOST_HALT) |-> $past(tmo_hit))
      else $error("Host halted before the timeout.");
   AST_GAP: assert property (@(posedge CLK) disable iff (RST || !CE)
      (DMA_BURST_END && !cfg.burst_long) |=> !DMA_BURST_ALLOW [*8])
      else $error("DMA burst gap too short.");
   AST_NARROW: assert property (@(posedge CLK) disable iff (RST)
      !WIDE_DRIVER_FITTED |-> (DMA_ADDR_OUT[21:18] == 4'h0))
      else $error("Upper DMA address lines driven without driver.");
   AST_VEC: assert property (@(posedge CLK) disable iff (RST)
      VEC_STROBE |-> (VEC_OUT == $past(vec_reg)))
      else $error("Vector differs from the written value.");
   AST_CHAIN: assert property (@(posedge CLK) disable iff (RST)
      (pend_reg && IAK_IN) |-> !IAK_OUT)
      else $error("Grant passed while requesting.");
endmodule
`default_nettype wire

// [dsc_host_model.sv]
// Host processor model for the controller's register port.
// Assumes a one-cycle strobe answered by a one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
   input wire logic clk,
   output logic [17:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic bus_ack
);
   initial begin
      bus_addr = '0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = '0;
   end

   // A write to the status word is how the host loads the interrupt vector.
   task automatic access(input logic w, input logic [17:0] a, input logic [15:0] wd,
                         output logic [15:0] rd, output logic ok);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= wd;
      bus_rd <= ~w;
      bus_wr <= w;
      @(posedge clk);
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      @(negedge clk);
      ok = bus_ack;
      rd = bus_rdata;
      // The released bus must not keep showing the last address or data.
      @(posedge clk);
      bus_addr <= ~a;
      bus_wdata <= ~wd;
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the switch configuration block.
// Assumes dsc_pkg, dsc_strap_config and dsc_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dsc_pkg::*;
   // Short boot timeout so that a failed autoboot shows within the run.
   localparam int unsigned TMO = 50;
   logic clk, rst, bus_rd, bus_wr, bus_ack, boot_req, host_halt, allow, idx_o, sec_o, iak_out, vec_strobe, ok;
   logic run_halt = 1'b0, fitted = 1'b0, burst_end = 1'b0, dev_irq = 1'b0, higher_req = 1'b0, iak_in = 1'b0;
   logic ce = 1'b1;
   logic idx_a = 1'b0, sec_a = 1'b0, idx_b = 1'b0, sec_b = 1'b0;
   logic [2:0] boot_unit;
   logic [3:0] first_unit, irq_lines;
   logic [7:0] drive_ready = 8'h00, vec_out;
   logic [15:0] bus_wdata, bus_rdata, d;
   logic [17:0] bus_addr;
   logic [21:0] dma_in = 22'h0, dma_out;
   dsc_sw_s sw = '0, s;
   int fails = 0, total_checks = 0;

   dsc_strap_config #(.BOOT_TIMEOUT_CYC(TMO)) dut (
      .CLK(clk), .RST(rst), .CE(ce), .RUN_HALT(run_halt), .SW(sw), .WIDE_DRIVER_FITTED(fitted),
      .BUS_ADDR(bus_addr), .BUS_RD(bus_rd), .BUS_WR(bus_wr), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
      .BUS_ACK(bus_ack), .DRIVE_READY(drive_ready), .BOOT_REQ(boot_req), .BOOT_UNIT(boot_unit),
      .HOST_HALT(host_halt), .FIRST_UNIT(first_unit), .DMA_BURST_END(burst_end), .DMA_BURST_ALLOW(allow),
      .DMA_ADDR_IN(dma_in), .DMA_ADDR_OUT(dma_out), .INDEX_A(idx_a), .SECTOR_A(sec_a), .INDEX_B(idx_b),
      .SECTOR_B(sec_b), .INDEX_PULSE(idx_o), .SECTOR_PULSE(sec_o), .DEV_IRQ(dev_irq),
      .HIGHER_REQ(higher_req), .IAK_IN(iak_in), .IAK_OUT(iak_out), .IRQ_LINES(irq_lines),
      .VEC_OUT(vec_out), .VEC_STROBE(vec_strobe));
   dsc_host_model host (.clk(clk), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic chk(input logic [21:0] got, input logic [21:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic give_up(input logic hit);
      if (hit) begin
         fails++;
         stop_test();
      end
   endtask

   // The eight bases are written out rather than computed, so a wrong step in the decode shows up.
   function automatic logic [17:0] base_of(input logic [2:0] c);
      case (c)
         3'h0: return 18'h3f468;
         3'h1: return 18'h3f46c;
         3'h2: return 18'h3e0dc;
         3'h3: return 18'h3e0e0;
         3'h4: return 18'h3e0e4;
         3'h5: return 18'h3e0e8;
         3'h6: return 18'h3e0ec;
         default: return 18'h3e0f0;
      endcase
   endfunction

   // Outside reset, switches are only taken on a run/halt release, so every setting meant to take effect goes through here.
   task automatic capture(input dsc_sw_s v);
      @(posedge clk);
      sw <= v;
      run_halt <= 1'b1;
      @(posedge clk);
      run_halt <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic rd(input logic [17:0] a);
      host.access(1'b0, a, 16'h0000, d, ok);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_addr();
      for (int c = 0; c < 8; c++) begin
         s = '0;
         s.addr_sel = 3'(c);
         capture(s);
         rd(base_of(3'(c)) + 18'h2);
         chk(22'(ok), 22'h1);
         chk(22'(d), 22'h0);
         rd(base_of(3'(c)));
         chk(22'(ok), 22'h1);
         rd(base_of(3'(c)) + 18'h4);
         chk(22'(ok), 22'h0);
         rd(base_of(3'(c) ^ 3'h1) + 18'h2);
         chk(22'(ok), 22'h0);
      end
   endtask

   task automatic t_boot();
      int n;
      s = '0;
      s.autoboot = 1'b1;
      s.unit_sel = 3'h3;
      @(posedge clk);
      drive_ready <= 8'h08;
      capture(s);
      repeat (3) @(negedge clk);
      chk(22'(boot_unit), 22'h3);
      chk(22'({boot_req, host_halt}), 22'h0);
      rd(DSC_STD_BASE + 18'h2);
      chk(22'(d), 22'h2000);
      // Unit 4 is out of the bootable range, so it must fail even with every drive ready.
      s.unit_sel = 3'h4;
      @(posedge clk);
      drive_ready <= 8'hff;
      capture(s);
      chk(22'(boot_req), 22'h1);
      n = 0;
      while (host_halt !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      give_up(n == 200);
      chk(22'(n > 44 && n < 53), 22'h1);
      rd(DSC_STD_BASE + 18'h2);
      chk(22'(d), 22'(16'hc000 | 16'(DSC_ERR_CODE_DEF)));
   endtask

   task automatic t_alt();
      for (int c = 0; c < 8; c++) begin
         s = '0;
         s.autoboot = 1'b1;
         s.addr_sel = 3'h1;
         s.unit_sel = 3'(c);
         capture(s);
         chk(22'(first_unit), (c == 0) ? 22'h8 : 22'(c));
         chk(22'(boot_req), 22'h0);
      end
      @(posedge clk);
      sw.unit_sel <= 3'h2;
      repeat (3) @(negedge clk);
      chk(22'(first_unit), 22'h7);
   endtask

   task automatic t_dma();
      int n;
      for (int l = 0; l < 2; l++) begin
         s = '0;
         s.burst_long = l[0];
         capture(s);
         chk(22'(allow), 22'h1);
         @(posedge clk);
         burst_end <= 1'b1;
         @(posedge clk);
         burst_end <= 1'b0;
         n = 0;
         @(negedge clk);
         while (allow !== 1'b1 && n < 400) begin
            n++;
            @(negedge clk);
         end
         give_up(n == 400);
         chk(22'(n), (l == 1) ? 22'(DSC_BURST_LONG_CYC) : 22'(DSC_BURST_SHORT_CYC));
      end
   endtask

   task automatic t_mux();
      for (int k = 0; k < 4; k++) begin
         s = '0;
         s.pulse_from_a = k[0];
         s.wide = k[1];
         @(posedge clk);
         fitted <= k[0];
         idx_a <= 1'b1;
         sec_b <= 1'b1;
         dma_in <= 22'h3fffff;
         capture(s);
         chk(22'({idx_o, sec_o}), k[0] ? 22'h2 : 22'h1);
         chk(dma_out, (k == 3) ? 22'h3fffff : 22'h03ffff);
      end
   endtask

   task automatic t_irq();
      s = '0;
      capture(s);
      host.access(1'b1, DSC_STD_BASE + 18'h2, 16'h005c, d, ok);
      chk(22'(ok), 22'h1);
      @(posedge clk);
      dev_irq <= 1'b1;
      higher_req <= 1'b1;
      iak_in <= 1'b1;
      @(posedge clk);
      dev_irq <= 1'b0;
      @(negedge clk);
      chk(22'({irq_lines, iak_out}), 22'h2);
      @(negedge clk);
      chk(22'(vec_strobe), 22'h0);
      @(posedge clk);
      higher_req <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk(22'({vec_strobe, vec_out}), 22'h15c);
      chk(22'({irq_lines, iak_out}), 22'h1);
      @(posedge clk);
      iak_in <= 1'b0;
   endtask

   // A reset in mid-run must take the switches as they stand, without a run/halt toggle.
   task automatic t_reset();
      s = '0;
      s.addr_sel = 3'h2;
      @(posedge clk);
      sw <= s;
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(base_of(3'h2) + 18'h2);
      chk(22'(ok), 22'h1);
      chk(22'(first_unit), 22'h8);
   endtask

   // Twenty cycles with the clock enable low must stretch the burst gap by exactly that much.
   task automatic t_hold();
      int n;
      s = '0;
      capture(s);
      @(posedge clk);
      burst_end <= 1'b1;
      @(posedge clk);
      burst_end <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      n = 0;
      @(negedge clk);
      while (allow !== 1'b1 && n < 400) begin
         n++;
         @(negedge clk);
      end
      give_up(n == 400);
      chk(22'(n), 22'(DSC_BURST_SHORT_CYC - 10));
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_addr();
      t_boot();
      t_alt();
      t_dma();
      t_mux();
      t_irq();
      t_reset();
      t_hold();
      stop_test();
   end
endmodule
`default_nettype wire
